// >>> core/udc_pkg.sv
package udc_pkg;
  // register word indices on apb
  localparam logic [7:0] OFF_INT_FLAGS = 8'he1;
  localparam logic [7:0] OFF_INT_ENABLE = 8'he2;
  localparam logic [7:0] OFF_ADDRESS = 8'he3;
  localparam logic [7:0] OFF_FRAME_LOW = 8'he4;
  localparam logic [7:0] OFF_FRAME_HIGH = 8'he5;
  localparam logic [7:0] OFF_FRAME_ERR = 8'he6;
  localparam logic [7:0] OFF_EP_SELECT = 8'he9;
  localparam logic [7:0] OFF_EP_RESET = 8'hea;
  localparam logic [7:0] OFF_EP_CONTROL = 8'heb;
  localparam logic [7:0] OFF_EP_CFG0 = 8'hec;
  localparam logic [7:0] OFF_EP_CFG1 = 8'hed;
  localparam logic [7:0] OFF_GLOBAL_IE = 8'hf0;
  // byte address is four times the printed index
  localparam int ADDR_SHIFT = 2;
  // interrupt flag and enable bit positions
  localparam int BIT_UPRSM = 6;
  localparam int BIT_EORSM = 5;
  localparam int BIT_WAKE = 4;
  localparam int BIT_EORST = 3;
  localparam int BIT_SOF = 2;
  localparam int BIT_SUSP = 0;
  localparam logic [7:0] INT_MASK = 8'h7d;
  // other field positions
  localparam int BIT_ADDR_EN = 7;
  localparam int BIT_FRAME_ERR = 4;
  localparam int BIT_STALL_RQ = 5;
  localparam int BIT_STALL_CLR = 4;
  localparam int BIT_TOGGLE_CLR = 3;
  localparam int BIT_EP_ON = 0;
  localparam int BIT_EP_DIR = 0;
  localparam int KIND_LSB = 6;
  localparam int BYTES_LSB = 4;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [10:0] RST_FRAME = 11'h000;
  // suspend idle time, 3 ms at 250 MHz
  localparam int SUSP_TIME_US = 3000;
  localparam int CLK_MHZ = 250;
  localparam int SUSP_CYCLES = SUSP_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    KIND_CONTROL,
    KIND_ISO,
    KIND_BULK,
    KIND_INTR
  } udc_kind_type;
  // per-endpoint state
  typedef struct packed {
    logic on;
    logic hold_reset;
    logic stall_request;
    udc_kind_type kind;
    logic direction;
    logic [2:0] bytes;
  } udc_ep_type;
  // events from the usb line engine
  typedef struct packed {
    logic upstream_resume;
    logic end_resume;
    logic wake;
    logic end_bus_reset;
    logic frame_start;
    logic frame_bad;
    logic [10:0] frame_count;
    logic bus_idle;
    logic stall_sent;
    logic setup_seen;
    logic [2:0] setup_ep;
  } udc_usb_ev_type;
endpackage : udc_pkg

// >>> core/udc_regs.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module udc_regs #(
  parameter int NUM_EP = 5,
  parameter int SUSP_CYCLES = udc_pkg::SUSP_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire udc_pkg::udc_usb_ev_type usb_ev,
  input wire logic [6:0] token_address,
  output logic address_match,
  output logic usb_int,
  output logic [NUM_EP-1:0] toggle_clear_pulse,
  output logic [NUM_EP-1:0] ep_enabled,
  output logic [NUM_EP-1:0] ep_in_reset,
  output logic [NUM_EP-1:0] ep_stall_pending,
  output logic [NUM_EP-1:0] ep_is_in
);
  logic [7:0] flags_reg;
  logic [7:0] enable_reg;
  logic global_ie_reg;
  logic [7:0] address_reg;
  logic [10:0] frame_reg;
  logic frame_err_reg;
  logic [2:0] ep_sel_reg;
  logic [31:0] idle_cnt_reg;
  logic idle_long;
  logic [31:0] prdata_next;
  logic wr;
  logic rd_ok;
  logic [7:0] wbyte;
  logic [7:0] reg_addr;
  logic [7:0] ev_set;
  udc_pkg::udc_ep_type ep_reg [NUM_EP];
  logic [7:0] flags_next;
  logic [31:0] idle_cnt_next;
  logic rd_setup;
  // per-register write strobes, one per landed access
  logic wr_flags;
  logic wr_enable;
  logic wr_global_ie;
  logic wr_address;
  logic wr_select;
  logic wr_ep_reset;
  logic wr_ep_control;
  logic wr_cfg0;
  logic wr_cfg1;
  // selected endpoint state for the read path
  udc_pkg::udc_ep_type ep_cur;
  logic ep_sel_valid;

  // apb decode, zero wait states, low byte lane carries data
  assign reg_addr = paddr[udc_pkg::ADDR_SHIFT +: 8];
  assign wr = psel && penable && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign pready = psel && penable;
  assign pslverr = psel && penable && !rd_ok;
  // read data is captured in the setup cycle
  assign rd_setup = psel && !penable && !pwrite;

  // decoded write strobes
  assign wr_flags = wr && (reg_addr == udc_pkg::OFF_INT_FLAGS);
  assign wr_enable = wr && (reg_addr == udc_pkg::OFF_INT_ENABLE);
  assign wr_global_ie = wr && (reg_addr == udc_pkg::OFF_GLOBAL_IE);
  assign wr_address = wr && (reg_addr == udc_pkg::OFF_ADDRESS);
  assign wr_select = wr && (reg_addr == udc_pkg::OFF_EP_SELECT);
  assign wr_ep_reset = wr && (reg_addr == udc_pkg::OFF_EP_RESET);
  assign wr_ep_control = wr && (reg_addr == udc_pkg::OFF_EP_CONTROL);
  assign wr_cfg0 = wr && (reg_addr == udc_pkg::OFF_EP_CFG0);
  assign wr_cfg1 = wr && (reg_addr == udc_pkg::OFF_EP_CFG1);

  // idle count: restarts on line activity, saturates one past the limit
  always_comb begin
    idle_cnt_next = idle_cnt_reg;
    if (!usb_ev.bus_idle) begin
      idle_cnt_next = 32'h0;
    end else if (!idle_long) begin
      idle_cnt_next = idle_cnt_reg + 32'h1;
    end
  end

  // idle counter register
  always_ff @(posedge mclk) begin
    if (reset) begin
      idle_cnt_reg <= 32'h0;
    end else begin
      idle_cnt_reg <= idle_cnt_next;
    end
  end
  // long idle once the count has passed the limit
  assign idle_long = idle_cnt_reg > 32'(SUSP_CYCLES);

  // hardware event set vector
  always_comb begin
    ev_set = 8'h00;
    ev_set[udc_pkg::BIT_UPRSM] = usb_ev.upstream_resume;
    ev_set[udc_pkg::BIT_EORSM] = usb_ev.end_resume;
    ev_set[udc_pkg::BIT_WAKE] = usb_ev.wake;
    ev_set[udc_pkg::BIT_EORST] = usb_ev.end_bus_reset;
    ev_set[udc_pkg::BIT_SOF] = usb_ev.frame_start;
    // one pulse per idle stretch, so a cleared flag stays clear
    ev_set[udc_pkg::BIT_SUSP] = usb_ev.bus_idle &&
      (idle_cnt_reg == 32'(SUSP_CYCLES));
  end

  // next flags: write zero clears, an event in the same cycle wins
  always_comb begin
    flags_next = flags_reg | ev_set;
    if (wr_flags) begin
      flags_next = (flags_reg & wbyte) | ev_set;
    end
    flags_next = flags_next & udc_pkg::INT_MASK;
  end

  // device flags register
  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_reg <= udc_pkg::RST_BYTE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // interrupt enables, reserved bits held at zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_reg <= udc_pkg::RST_BYTE;
    end else if (wr_enable) begin
      enable_reg <= wbyte & udc_pkg::INT_MASK;
    end
  end

  // global interrupt enable, stands in for the cpu status word
  always_ff @(posedge mclk) begin
    if (reset) begin
      global_ie_reg <= 1'b0;
    end else if (wr_global_ie) begin
      global_ie_reg <= wbyte[0];
    end
  end

  // device address and its enable bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      address_reg <= udc_pkg::RST_BYTE;
    end else if (wr_address) begin
      address_reg <= wbyte;
    end
  end

  // endpoint select
  always_ff @(posedge mclk) begin
    if (reset) begin
      ep_sel_reg <= 3'h0;
    end else if (wr_select) begin
      ep_sel_reg <= wbyte[2:0];
    end
  end

  // interrupt request
  assign usb_int = global_ie_reg && |(flags_reg & enable_reg);

  // address match toward the line engine
  assign address_match = address_reg[udc_pkg::BIT_ADDR_EN] &&
    (address_reg[6:0] == token_address);

  // frame number capture, corrupted frames included
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_reg <= udc_pkg::RST_FRAME;
    end else if (usb_ev.frame_start) begin
      frame_reg <= usb_ev.frame_count;
    end
  end

  // crc error bit, refreshed on each frame token
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_err_reg <= 1'b0;
    end else if (usb_ev.frame_start) begin
      frame_err_reg <= usb_ev.frame_bad;
    end
  end

  // per-endpoint state copies
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      logic sel;
      logic stall_hw_clr;
      logic ctl_hit;
      logic cfg0_hit;
      logic cfg1_hit;
      logic tgl_reg;
      // this copy is the one the select register names
      assign sel = (ep_sel_reg == 3'(gi));
      // writes that reach this endpoint through the select register
      assign ctl_hit = wr_ep_control && sel;
      assign cfg0_hit = wr_cfg0 && sel;
      assign cfg1_hit = wr_cfg1 && sel;
      // a sent stall clears every endpoint, a setup only its own
      assign stall_hw_clr = usb_ev.stall_sent ||
        (usb_ev.setup_seen && usb_ev.setup_ep == 3'(gi));
      // configuration and control fields of this endpoint
      always_ff @(posedge mclk) begin
        if (reset) begin
          ep_reg[gi] <= '0;
        end else begin
          if (wr_ep_reset) begin
            ep_reg[gi].hold_reset <= wbyte[gi];
          end
          if (ctl_hit) begin
            ep_reg[gi].on <= wbyte[udc_pkg::BIT_EP_ON];
          end
          // a written request wins over a hardware clear in one cycle
          if (ctl_hit && wbyte[udc_pkg::BIT_STALL_RQ]) begin
            ep_reg[gi].stall_request <= 1'b1;
          end else if (stall_hw_clr) begin
            ep_reg[gi].stall_request <= 1'b0;
          end else if (ctl_hit && wbyte[udc_pkg::BIT_STALL_CLR]) begin
            ep_reg[gi].stall_request <= 1'b0;
          end
          if (cfg0_hit) begin
            ep_reg[gi].kind <= udc_pkg::udc_kind_type'(wbyte[udc_pkg::KIND_LSB +: 2]);
            ep_reg[gi].direction <= wbyte[udc_pkg::BIT_EP_DIR];
          end
          if (cfg1_hit) begin
            ep_reg[gi].bytes <= wbyte[udc_pkg::BYTES_LSB +: 3];
          end
        end
      end
      // toggle clear is a one-cycle pulse, never stored
      always_ff @(posedge mclk) begin
        if (reset) begin
          tgl_reg <= 1'b0;
        end else begin
          tgl_reg <= ctl_hit && wbyte[udc_pkg::BIT_TOGGLE_CLR];
        end
      end
      assign toggle_clear_pulse[gi] = tgl_reg;
      assign ep_enabled[gi] = ep_reg[gi].on;
      assign ep_in_reset[gi] = ep_reg[gi].hold_reset;
      assign ep_stall_pending[gi] = ep_reg[gi].stall_request;
      assign ep_is_in[gi] = (ep_reg[gi].kind != udc_pkg::KIND_CONTROL) &&
        ep_reg[gi].direction;
    end
  endgenerate

  // selected endpoint copy, zero when the select names no endpoint
  assign ep_sel_valid = int'(ep_sel_reg) < NUM_EP;
  always_comb begin
    ep_cur = '0;
    if (ep_sel_valid) begin
      ep_cur = ep_reg[ep_sel_reg];
    end
  end

  // read mux, reserved bits zero
  always_comb begin
    prdata_next = 32'h0;
    rd_ok = 1'b1;
    case (reg_addr)
      udc_pkg::OFF_INT_FLAGS: begin
        prdata_next[7:0] = flags_reg;
      end
      udc_pkg::OFF_INT_ENABLE: begin
        prdata_next[7:0] = enable_reg;
      end
      udc_pkg::OFF_GLOBAL_IE: begin
        prdata_next[0] = global_ie_reg;
      end
      udc_pkg::OFF_ADDRESS: begin
        prdata_next[7:0] = address_reg;
      end
      udc_pkg::OFF_FRAME_LOW: begin
        prdata_next[7:0] = frame_reg[7:0];
      end
      udc_pkg::OFF_FRAME_HIGH: begin
        prdata_next[2:0] = frame_reg[10:8];
      end
      udc_pkg::OFF_FRAME_ERR: begin
        prdata_next[udc_pkg::BIT_FRAME_ERR] = frame_err_reg;
      end
      udc_pkg::OFF_EP_SELECT: begin
        prdata_next[2:0] = ep_sel_reg;
      end
      udc_pkg::OFF_EP_RESET: begin
        for (int i = 0; i < NUM_EP; i++) begin
          prdata_next[i] = ep_reg[i].hold_reset;
        end
      end
      udc_pkg::OFF_EP_CONTROL: begin
        prdata_next[udc_pkg::BIT_STALL_RQ] = ep_cur.stall_request;
        prdata_next[udc_pkg::BIT_EP_ON] = ep_cur.on;
      end
      udc_pkg::OFF_EP_CFG0: begin
        prdata_next[7:6] = ep_cur.kind;
        prdata_next[0] = ep_cur.direction;
      end
      udc_pkg::OFF_EP_CFG1: begin
        prdata_next[6:4] = ep_cur.bytes;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // registered read data
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= prdata_next;
    end
  end
endmodule : udc_regs

// >>> tb/tb_usb_device_ctrl_regs.sv
`timescale 1ns/1ps
module tb_usb_device_ctrl_regs;
  localparam int SUSP = 20;
  localparam logic [7:0] FL = udc_pkg::OFF_INT_FLAGS;
  localparam logic [7:0] GIE = udc_pkg::OFF_GLOBAL_IE;
  localparam logic [7:0] CTL = udc_pkg::OFF_EP_CONTROL;
  localparam logic [7:0] SEL = udc_pkg::OFF_EP_SELECT;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, err, address_match, usb_int;
  udc_pkg::udc_usb_ev_type usb_ev;
  logic [6:0] token_address;
  logic [4:0] ep_on, ep_rst, ep_stall, ep_in, tgl;
  int n_mismatch = 0;
  int check_count = 0;
  // free-running clock
  always #2 mclk = ~mclk;
  udc_regs #(.SUSP_CYCLES(SUSP)) uut (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_ev(usb_ev),
    .token_address(token_address), .address_match(address_match), .usb_int(usb_int),
    .toggle_clear_pulse(tgl), .ep_enabled(ep_on), .ep_in_reset(ep_rst),
    .ep_stall_pending(ep_stall), .ep_is_in(ep_in));
  udc_host_model host (.mclk(mclk), .usb_ev(usb_ev), .token_address(token_address));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, i, 8'h00, q);
    chk(nm, e, q);
  endtask : rd
  task automatic t_reset;
    for (int k = 0; k < 8; k++) begin
      rd(8'he1 + 8'(k), 32'h0, "reset value");
    end
    rd(8'he7, 32'h0, "unmapped read");
    chk("unmapped error", 1, err);
    $display("reset test done");
  endtask : t_reset
  task automatic t_flags;
    host.events(4'hf);
    rd(FL, 32'h78, "event flags");
    chk("masked int", 0, usb_int);
    wr(FL, 8'hff);
    rd(FL, 32'h78, "flags after ones");
    host.idle(SUSP - 2);
    rd(FL, 32'h78, "early suspend");
    host.idle(SUSP + 2);
    rd(FL, 32'h79, "suspend flag");
    wr(udc_pkg::OFF_INT_ENABLE, 8'h01);
    wr(GIE, 8'h01); #1;
    chk("int on", 1, usb_int);
    wr(GIE, 8'h00); #1;
    chk("int global off", 0, usb_int);
    wr(GIE, 8'h01);
    wr(FL, 8'hfe); #1;
    chk("int cleared", 0, usb_int);
    rd(FL, 32'h78, "suspend cleared");
    $display("flag test done");
  endtask : t_flags
  task automatic t_frame;
    wr(FL, 8'h00);
    host.sof(11'h5a3, 1'b0);
    rd(udc_pkg::OFF_FRAME_LOW, 32'ha3, "frame low");
    rd(udc_pkg::OFF_FRAME_HIGH, 32'h5, "frame high");
    rd(FL, 32'h04, "frame flag");
    wr(FL, 8'h00);
    host.sof(11'h7ff, 1'b1);
    rd(udc_pkg::OFF_FRAME_ERR, 32'h10, "crc error");
    rd(udc_pkg::OFF_FRAME_HIGH, 32'h7, "bad frame high");
    rd(FL, 32'h04, "bad frame flag");
    $display("frame test done");
  endtask : t_frame
  task automatic t_addr;
    @(posedge mclk);
    host.token_address <= 7'h2a;
    wr(udc_pkg::OFF_ADDRESS, 8'h2a); #1;
    chk("match off", 0, address_match);
    wr(udc_pkg::OFF_ADDRESS, 8'haa); #1;
    chk("match on", 1, address_match);
    @(posedge mclk);
    host.token_address <= 7'h2b; #1;
    chk("other addr", 0, address_match);
    $display("address test done");
  endtask : t_addr
  task automatic t_ep;
    wr(SEL, 8'h00);
    wr(CTL, 8'h01);
    wr(SEL, 8'h02);
    wr(CTL, 8'h29); #1;
    chk("enables", 5'h05, ep_on);
    chk("stall", 5'h04, ep_stall);
    chk("toggle pulse", 5'h04, tgl);
    rd(CTL, 32'h21, "ctl readback");
    wr(CTL, 8'h11);
    rd(CTL, 32'h01, "stall cancel");
    wr(CTL, 8'h21);
    host.setup(3'd2); #1;
    chk("stall by setup", 0, ep_stall);
    for (int k = 0; k < 4; k++) begin
      wr(udc_pkg::OFF_EP_CFG0, {2'(k), 6'h01});
      rd(udc_pkg::OFF_EP_CFG0, {24'h0, 2'(k), 6'h01}, "kind");
      chk("direction", k != 0, ep_in[2]);
    end
    wr(udc_pkg::OFF_EP_CFG1, 8'hb0);
    rd(udc_pkg::OFF_EP_CFG1, 32'h30, "size");
    wr(udc_pkg::OFF_EP_RESET, 8'h04); #1;
    chk("ep reset", 5'h04, ep_rst);
    wr(udc_pkg::OFF_EP_RESET, 8'h00);
    wr(CTL, 8'h00); #1;
    chk("disable", 5'h01, ep_on);
    wr(SEL, 8'h00);
    rd(udc_pkg::OFF_EP_CFG1, 32'h0, "ep0 size");
    rd(CTL, 32'h01, "ep0 ctl");
    $display("endpoint test done");
  endtask : t_ep
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    give_verdict;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_flags;
    t_frame;
    t_addr;
    t_ep;
    give_verdict;
  end
endmodule : tb_usb_device_ctrl_regs

// >>> tb/udc_host_model.sv
`timescale 1ns/1ps
module udc_host_model (
  input wire logic mclk,
  output udc_pkg::udc_usb_ev_type usb_ev,
  output logic [6:0] token_address
);
  // quiet line at start
  initial begin
    usb_ev = '0;
    token_address = 7'h00;
  end
  // one-cycle line events, mask upper four kinds
  task automatic events(input logic [3:0] m);
    @(posedge mclk);
    usb_ev[22:19] <= m;
    @(posedge mclk);
    usb_ev[22:19] <= 4'h0;
  endtask : events
  // frame token; number goes stale after it
  task automatic sof(input logic [10:0] n, input logic bad);
    @(posedge mclk);
    usb_ev.frame_start <= 1'b1;
    usb_ev.frame_bad <= bad;
    usb_ev.frame_count <= n;
    @(posedge mclk);
    usb_ev.frame_start <= 1'b0;
    usb_ev.frame_count <= ~n;
  endtask : sof
  // idle line for n cycles
  task automatic idle(input int n);
    @(posedge mclk);
    usb_ev.bus_idle <= 1'b1;
    repeat (n) @(posedge mclk);
    usb_ev.bus_idle <= 1'b0;
  endtask : idle
  // setup token to an endpoint
  task automatic setup(input logic [2:0] e);
    @(posedge mclk);
    usb_ev.setup_seen <= 1'b1;
    usb_ev.setup_ep <= e;
    @(posedge mclk);
    usb_ev.setup_seen <= 1'b0;
    usb_ev.setup_ep <= ~e;
  endtask : setup
endmodule : udc_host_model

// >>> tb/udc_regs_checker.sv
`timescale 1ns/1ps
module udc_regs_checker #(
  parameter int NUM_EP = 5
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire udc_pkg::udc_usb_ev_type usb_ev,
  input wire logic [6:0] token_address,
  input wire logic address_match,
  input wire logic usb_int,
  input wire logic [NUM_EP-1:0] toggle_clear_pulse,
  input wire logic [NUM_EP-1:0] ep_enabled,
  input wire logic [NUM_EP-1:0] ep_in_reset,
  input wire logic [NUM_EP-1:0] ep_stall_pending
);
  logic wr;
  logic ev;
  // landed writes and line events
  assign wr = psel & penable & pwrite;
  assign ev = (|usb_ev[22:18]) | usb_ev.bus_idle;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_pulse; |toggle_clear_pulse; endsequence
  property p_int_cause; $rose(usb_int) |-> $past(ev | wr); endproperty
  a_int_cause: assert property (p_int_cause) else $error("int rose uncaused");
  property p_addr_rise; $rose(address_match) |-> $past(wr) || $changed(token_address); endproperty
  a_addr_rise: assert property (p_addr_rise) else $error("match rose uncaused");
  property p_stall_clr;
    |(~ep_stall_pending & $past(ep_stall_pending)) |->
      $past(wr | usb_ev.stall_sent | usb_ev.setup_seen);
  endproperty
  a_stall_clr: assert property (p_stall_clr) else $error("stall dropped");
  property p_en_write; !$stable(ep_enabled) |-> $past(wr | usb_ev.end_bus_reset); endproperty
  a_en_write: assert property (p_en_write) else $error("enable changed");
  property p_rst_write;
    !$stable(ep_in_reset) |-> $past(wr && paddr == {22'h0, udc_pkg::OFF_EP_RESET, 2'b00});
  endproperty
  a_rst_write: assert property (p_rst_write) else $error("ep reset changed");
  property p_tgl_cause; $rose(|toggle_clear_pulse) |-> $past(wr) || $past(wr, 2); endproperty
  a_tgl_cause: assert property (p_tgl_cause) else $error("toggle pulse uncaused");
  property p_tgl_once; s_pulse |=> toggle_clear_pulse == '0; endproperty
  a_tgl_once: assert property (p_tgl_once) else $error("toggle pulse long");
  property p_hi_zero;
    pready && !pwrite && paddr == {22'h0, udc_pkg::OFF_FRAME_HIGH, 2'b00} |-> prdata[31:3] == '0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("frame high reserved set");
endmodule : udc_regs_checker
bind udc_regs udc_regs_checker #(.NUM_EP(NUM_EP)) u_chk (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .usb_ev(usb_ev),
  .token_address(token_address), .address_match(address_match), .usb_int(usb_int),
  .toggle_clear_pulse(toggle_clear_pulse), .ep_enabled(ep_enabled),
  .ep_in_reset(ep_in_reset), .ep_stall_pending(ep_stall_pending)
);
